// [hw/rtcs_top.sv]
// Clock, calendar, alarm, watchdog and SRAM bank control behind a byte SRAM port
//
// Summary of operation
// R1: Sixteen byte registers accessed like static memory.
// R2: Clock bytes are cells, refreshed once per second.
// R3: Calendar handles short months and leap years.
// R4: Offset 8h holds access control and calibration.
// R5: Offset 7h holds the watchdog timeout setting.
// R6: Watchdog expiry drives reset or interrupt, steered.
// R7: Alarm fires when month..second bytes match.
// R8: Offset 1h holds the century.
// R9: Offset 0h reports watchdog, alarm, battery flags.
// R10: Supply fail blocks register and SRAM writes.
// R11: Both SRAM enables forced off during fail.
// R12: Two external SRAM chip enable outputs.
// R13: Four-bit address picks one register under enable.
// R14: Bank select steers enables; external enable gates both.
// R15: Read with enable low, write high; drive on output enable.
// R16: Write spans later fall to earlier rise.
module rtcs_top
  import rtcs_pkg::*;
#(
  parameter int unsigned SUB_CYCLES = rtcs_pkg::SUB_CYCLES_DEF
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Register port, all controls active low
  input wire logic chip_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic write_enable_n_in,
  input wire logic [3:0] register_address_in,
  input wire logic [7:0] data_bus_in,
  output logic [7:0] data_bus_out,
  output logic data_bus_oe_out,
  // External SRAM control, active low except the bank select level
  input wire logic external_memory_select_in,
  input wire logic bank_select_in,
  output logic sram_bank0_select_out,
  output logic sram_bank1_select_out,
  // Supervisor
  input wire logic supply_fail_in,
  input wire logic battery_low_in,
  input wire logic watchdog_kick_in,
  input wire logic reset_request_in_a,
  input wire logic reset_request_in_b,
  output logic reset_out,
  output logic reset_oe_out,
  output logic interrupt_freqtest_out,
  output logic interrupt_freqtest_oe_out
);
  import rtcs_pkg::*;

  function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] top,
                                          input logic [7:0] low);
    if (v >= top) begin
      return low;
    end
    if (v[3:0] >= 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_next

  // Every fourth year; no century exception, good through 2099
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction : is_leap

  function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: month_end = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
      default: month_end = 8'h31;
    endcase
  endfunction : month_end

  // Register cells
  logic [7:0] regs_q [16];
  rtcs_time_s cnt_q;
  rtcs_time_s cnt_d;

  // Host access tracking
  logic wr_act_q;
  logic rd_act_q;
  logic [3:0] acc_addr_q;
  logic [7:0] wr_data_q;
  logic kick_prev_q;
  logic refresh_q;

  // Prescaler
  logic [31:0] sub_cnt_q;
  logic [3:0] sub_idx_q;

  // Watchdog
  rtcs_wd_e wd_state_q;
  logic [10:0] wd_cnt_q;
  logic [3:0] rst_left_q;

  wire access_sel = ~chip_enable_n_in; // [R13]
  wire wr_now = access_sel & ~write_enable_n_in; // [R16]
  wire rd_now = access_sel & write_enable_n_in; // [R15]
  wire wr_end = wr_act_q & ~wr_now; // [R16]
  wire rd_end = rd_act_q & ~rd_now;
  wire wr_commit = wr_end & ~supply_fail_in; // [R10]

  wire [7:0] ctl = regs_q[OFF_CONTROL];
  wire [7:0] wd_set = regs_q[OFF_WATCHDOG];
  wire [7:0] flags = regs_q[OFF_FLAGS];
  wire osc_stop = regs_q[OFF_SEC][SEC_STOP];

  // Releasing the write bit loads the host's time into the counters
  wire time_load = wr_commit & (acc_addr_q == OFF_CONTROL) & ctl[CTL_WRITE] &
                   ~wr_data_q[CTL_WRITE];
  // Refresh halts while host holds either access bit
  wire refresh_ok = ~ctl[CTL_WRITE] & ~ctl[CTL_READ]; // [R4]

  // Calibration nudges only the first sixteenth of each second
  // A negative trim larger than one sixteenth would wrap the length,
  // so small simulation prescalers must keep the trim at zero
  wire [31:0] cal_adj = CAL_STEP_CYCLES * {27'h0, ctl[4:0]}; // [R4]
  wire [31:0] sub_len = (sub_idx_q != 4'h0) ? SUB_CYCLES :
                        ctl[CTL_SIGN] ? SUB_CYCLES + cal_adj : SUB_CYCLES - cal_adj;
  wire sub_tick = ~osc_stop & (sub_cnt_q >= sub_len - 32'h1);
  wire sec_tick = sub_tick & (sub_idx_q == LAST_SUBTICK);

  // Calendar cascade
  wire sec_wrap = cnt_q.sec[6:0] >= 7'h59;
  wire min_wrap = sec_wrap & (cnt_q.min[6:0] >= 7'h59);
  wire hour_wrap = min_wrap & (cnt_q.hour[5:0] >= 6'h23);
  wire date_wrap = hour_wrap & (cnt_q.date >= month_end(cnt_q.month, cnt_q.year)); // [R3]
  wire month_wrap = date_wrap & (cnt_q.month >= 8'h12);
  wire year_wrap = month_wrap & (cnt_q.year >= 8'h99);

  always_comb begin
    cnt_d = cnt_q;
    if (time_load) begin
      cnt_d.sec = {1'b0, regs_q[OFF_SEC][6:0]};
      cnt_d.min = regs_q[OFF_MIN];
      cnt_d.hour = regs_q[OFF_HOUR];
      cnt_d.day = regs_q[OFF_DAY];
      cnt_d.date = regs_q[OFF_DATE];
      cnt_d.month = regs_q[OFF_MONTH];
      cnt_d.year = regs_q[OFF_YEAR];
      cnt_d.century = regs_q[OFF_CENTURY];
    end else if (sec_tick) begin
      cnt_d.sec = bcd_next(cnt_q.sec, 8'h59, 8'h00);
      if (sec_wrap) begin
        cnt_d.min = bcd_next(cnt_q.min, 8'h59, 8'h00);
      end
      if (min_wrap) begin
        cnt_d.hour = bcd_next(cnt_q.hour, 8'h23, 8'h00);
      end
      if (hour_wrap) begin
        cnt_d.day = bcd_next(cnt_q.day, 8'h07, 8'h01);
        cnt_d.date = bcd_next(cnt_q.date, month_end(cnt_q.month, cnt_q.year), 8'h01); // [R3]
      end
      if (date_wrap) begin
        cnt_d.month = bcd_next(cnt_q.month, 8'h12, 8'h01);
      end
      if (month_wrap) begin
        cnt_d.year = bcd_next(cnt_q.year, 8'h99, 8'h00);
      end
      if (year_wrap) begin
        cnt_d.century = bcd_next(cnt_q.century, 8'h99, 8'h00); // [R8]
      end
    end
  end

  // Alarm compares on each refresh, against the freshly stored time
  wire alarm_hit = refresh_q &
    (regs_q[OFF_ALM_MONTH][4:0] == cnt_q.month[4:0]) &
    (regs_q[OFF_ALM_DATE][5:0] == cnt_q.date[5:0]) &
    (regs_q[OFF_ALM_HOUR][5:0] == cnt_q.hour[5:0]) &
    (regs_q[OFF_ALM_MIN][6:0] == cnt_q.min[6:0]) &
    (regs_q[OFF_ALM_SEC][6:0] == cnt_q.sec[6:0]); // [R7]

  // Watchdog: multiplier in units of 1/16, 1/4, 1 or 4 seconds
  wire [10:0] wd_limit = {6'h00, wd_set[6:2]} << {wd_set[1:0], 1'b0}; // [R5]
  wire wd_kick = (watchdog_kick_in ^ kick_prev_q) |
                 (wr_commit & (acc_addr_q == OFF_WATCHDOG));
  wire wd_fire = (wd_state_q == WD_RUN) & sub_tick & ~wd_kick &
                 (wd_cnt_q >= wd_limit - 11'h1);

  // Flags: hardware set wins over the read clear
  // Clearing on the end of the read keeps the byte stable while it is driven
  wire flag_clear = rd_end & (acc_addr_q == OFF_FLAGS);
  wire wd_flag_d = wd_fire | (flags[FLG_WATCHDOG] & ~flag_clear); // [R9]
  wire alm_flag_d = alarm_hit | (flags[FLG_ALARM] & ~flag_clear); // [R9] [R7]
  wire [7:0] flags_d = {wd_flag_d, alm_flag_d, 1'b0, battery_low_in, 4'h0}; // [R9]

  // Read path and pin outputs
  wire [7:0] rd_data = regs_q[register_address_in]; // [R13] [R1]
  wire drive_d = rd_now & ~output_enable_n_in & ~supply_fail_in; // [R15]
  wire ext_sel = ~external_memory_select_in & ~supply_fail_in; // [R10] [R11]
  wire bank0_d = ~(ext_sel & ~bank_select_in); // [R14] [R12]
  wire bank1_d = ~(ext_sel & bank_select_in); // [R14] [R12]
  wire irq_d = (flags[FLG_ALARM] & regs_q[OFF_ALM_MONTH][ALM_ENABLE]) |
               (flags[FLG_WATCHDOG] & wd_set[WD_ROUTE]); // [R6]
  wire rst_d = (rst_left_q != 4'h0) | ~reset_request_in_a | ~reset_request_in_b |
               supply_fail_in;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      acc_addr_q <= 4'h0;
      wr_data_q <= REG_RESET;
      kick_prev_q <= 1'b0;
    end else begin
      wr_act_q <= wr_now;
      rd_act_q <= rd_now;
      kick_prev_q <= watchdog_kick_in;
      if (wr_now | rd_now) begin
        acc_addr_q <= register_address_in; // [R16]
      end
      if (wr_now) begin
        wr_data_q <= data_bus_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sub_cnt_q <= 32'h0;
      sub_idx_q <= 4'h0;
      refresh_q <= 1'b0;
    end else begin
      refresh_q <= sec_tick & refresh_ok; // [R2]
      if (time_load) begin
        sub_cnt_q <= 32'h0;
        sub_idx_q <= 4'h0;
      end else if (sub_tick) begin
        sub_cnt_q <= 32'h0;
        sub_idx_q <= sub_idx_q + 4'h1;
      end else if (!osc_stop) begin
        sub_cnt_q <= sub_cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '{century: REG_RESET, year: REG_RESET, month: ONE_RESET, date: ONE_RESET,
                 day: ONE_RESET, hour: REG_RESET, min: REG_RESET, sec: REG_RESET};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Host writes take priority; the refresh skips while W or R is held
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= REG_RESET;
      end
      regs_q[OFF_DAY] <= ONE_RESET;
      regs_q[OFF_DATE] <= ONE_RESET;
      regs_q[OFF_MONTH] <= ONE_RESET;
    end else begin
      if (refresh_q) begin
        regs_q[OFF_SEC] <= {regs_q[OFF_SEC][SEC_STOP], cnt_q.sec[6:0]}; // [R2]
        regs_q[OFF_MIN] <= cnt_q.min;
        regs_q[OFF_HOUR] <= cnt_q.hour;
        regs_q[OFF_DAY] <= cnt_q.day;
        regs_q[OFF_DATE] <= cnt_q.date;
        regs_q[OFF_MONTH] <= cnt_q.month;
        regs_q[OFF_YEAR] <= cnt_q.year;
        regs_q[OFF_CENTURY] <= cnt_q.century; // [R8]
      end
      if (wr_commit && acc_addr_q != OFF_FLAGS) begin
        regs_q[acc_addr_q] <= wr_data_q; // [R1] [R10]
      end
      regs_q[OFF_FLAGS] <= flags_d; // [R9]
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd_state_q <= WD_OFF;
      wd_cnt_q <= 11'h0;
      rst_left_q <= 4'h0;
    end else begin
      case (wd_state_q)
        WD_OFF: begin
          wd_cnt_q <= 11'h0;
          if (wd_limit != 11'h0) begin
            wd_state_q <= WD_RUN;
          end
        end
        WD_RUN: begin
          if (wd_limit == 11'h0) begin
            wd_state_q <= WD_OFF;
          end else if (wd_kick) begin
            wd_cnt_q <= 11'h0;
          end else if (wd_fire) begin
            wd_state_q <= WD_DONE;
          end else if (sub_tick) begin
            wd_cnt_q <= wd_cnt_q + 11'h1;
          end
        end
        WD_DONE: begin
          wd_cnt_q <= 11'h0;
          if (wd_kick) begin
            wd_state_q <= WD_OFF;
          end
        end
        default: wd_state_q <= WD_OFF;
      endcase
      if (wd_fire && !wd_set[WD_ROUTE]) begin
        rst_left_q <= RST_HOLD_SUBTICKS; // [R6]
      end else if (sub_tick && rst_left_q != 4'h0) begin
        rst_left_q <= rst_left_q - 4'h1;
      end
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_bus_out <= 8'h00;
      data_bus_oe_out <= 1'b0;
      sram_bank0_select_out <= 1'b1;
      sram_bank1_select_out <= 1'b1;
      reset_out <= 1'b0;
      reset_oe_out <= 1'b1;
      interrupt_freqtest_out <= 1'b0;
      interrupt_freqtest_oe_out <= 1'b0;
    end else begin
      data_bus_out <= rd_data; // [R15]
      data_bus_oe_out <= drive_d; // [R15]
      sram_bank0_select_out <= bank0_d; // [R11]
      sram_bank1_select_out <= bank1_d; // [R11]
      reset_out <= 1'b0;
      reset_oe_out <= rst_d; // [R6]
      interrupt_freqtest_out <= 1'b0;
      interrupt_freqtest_oe_out <= irq_d; // [R6]
    end
  end

endmodule : rtcs_top

// [hw/rtcs_pkg.sv]
// Constants, register map and time carrier for the clock supervisor block
package rtcs_pkg;

  // Register offsets
  localparam logic [3:0] OFF_FLAGS = 4'h0;
  localparam logic [3:0] OFF_CENTURY = 4'h1;
  localparam logic [3:0] OFF_ALM_MONTH = 4'h2;
  localparam logic [3:0] OFF_ALM_DATE = 4'h3;
  localparam logic [3:0] OFF_ALM_HOUR = 4'h4;
  localparam logic [3:0] OFF_ALM_MIN = 4'h5;
  localparam logic [3:0] OFF_ALM_SEC = 4'h6;
  localparam logic [3:0] OFF_WATCHDOG = 4'h7;
  localparam logic [3:0] OFF_CONTROL = 4'h8;
  localparam logic [3:0] OFF_SEC = 4'h9;
  localparam logic [3:0] OFF_MIN = 4'hA;
  localparam logic [3:0] OFF_HOUR = 4'hB;
  localparam logic [3:0] OFF_DAY = 4'hC;
  localparam logic [3:0] OFF_DATE = 4'hD;
  localparam logic [3:0] OFF_MONTH = 4'hE;
  localparam logic [3:0] OFF_YEAR = 4'hF;

  // Field positions
  localparam int FLG_WATCHDOG = 7;
  localparam int FLG_ALARM = 6;
  localparam int FLG_BATT_LOW = 4;
  localparam int CTL_WRITE = 7;
  localparam int CTL_READ = 6;
  localparam int CTL_SIGN = 5;
  localparam int WD_ROUTE = 7;
  localparam int ALM_ENABLE = 7;
  localparam int SEC_STOP = 7;

  // Values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ONE_RESET = 8'h01;

  // Timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SEC_MS = 1000;
  localparam int unsigned SUBTICKS = 16;
  localparam int unsigned ONE_SEC_CYCLES = SEC_MS * 1000 * CLK_MHZ;
  localparam int unsigned SUB_CYCLES_DEF = ONE_SEC_CYCLES / SUBTICKS;
  localparam logic [31:0] CAL_STEP_CYCLES = 32'h0000_0004;
  localparam logic [3:0] LAST_SUBTICK = 4'hF;
  localparam logic [3:0] RST_HOLD_SUBTICKS = 4'h2;

  typedef struct packed {
    logic [7:0] century;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtcs_time_s;

  typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_DONE} rtcs_wd_e;

endpackage : rtcs_pkg

// [bench/rtcs_checker.sv]
// Port assertions for the clock supervisor block
module rtcs_checker (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic chip_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic write_enable_n_in,
  input wire logic data_bus_oe_out,
  // Bank control
  input wire logic external_memory_select_in,
  input wire logic bank_select_in,
  input wire logic supply_fail_in,
  input wire logic sram_bank0_select_out,
  input wire logic sram_bank1_select_out
);
  wire sel_ok = !external_memory_select_in && !supply_fail_in;
  wire rd = !chip_enable_n_in && write_enable_n_in && !output_enable_n_in;
  wire b0 = sram_bank0_select_out;
  wire b1 = sram_bank1_select_out;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_bank0; sel_ok && !bank_select_in |=> !b0 && b1; endproperty
  a_bank0: assert property (p_bank0) else $error("bank 0 select wrong");
  property p_bank1; sel_ok && bank_select_in |=> b0 && !b1; endproperty
  a_bank1: assert property (p_bank1) else $error("bank 1 select wrong");
  property p_ext_off; external_memory_select_in |=> b0 && b1; endproperty
  a_ext_off: assert property (p_ext_off) else $error("banks on while deselected");
  property p_fail_off; supply_fail_in [*2] |-> b0 && b1; endproperty
  a_fail_off: assert property (p_fail_off) else $error("banks on during fail");
  property p_one_bank; b0 || b1; endproperty
  a_one_bank: assert property (p_one_bank) else $error("both banks selected");
  property p_read_drive; rd && !supply_fail_in |=> data_bus_oe_out; endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");
  property p_no_drive; !rd |=> !data_bus_oe_out; endproperty
  a_no_drive: assert property (p_no_drive) else $error("bus driven outside read");
  property p_fail_quiet; supply_fail_in |=> !data_bus_oe_out; endproperty
  a_fail_quiet: assert property (p_fail_quiet) else $error("bus driven in fail");
endmodule : rtcs_checker

bind rtcs_top rtcs_checker u_chk (.ref_clk_in, .rst_n_in, .chip_enable_n_in,
  .output_enable_n_in, .write_enable_n_in, .data_bus_oe_out, .external_memory_select_in,
  .bank_select_in, .supply_fail_in, .sram_bank0_select_out, .sram_bank1_select_out);

// [bench/rtcs_sram_model.sv]
// Behavioural two-bank external static memory
module rtcs_sram_model (
  // Clock
  input wire logic clk_in,
  // Controls, active low
  input wire logic bank0_n_in,
  input wire logic bank1_n_in,
  input wire logic we_n_in,
  // Data
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [2];
  logic [7:0] idle_q = 8'h5A;
  // Deselected memory shows a moving pattern, never a stale byte
  always @(posedge clk_in) begin
    idle_q <= ~idle_q;
    if (!we_n_in && !bank0_n_in) mem_q[0] <= wdata_in;
    if (!we_n_in && !bank1_n_in) mem_q[1] <= wdata_in;
  end
  assign rdata_out = !bank0_n_in ? mem_q[0] : (!bank1_n_in ? mem_q[1] : idle_q);
endmodule : rtcs_sram_model

// [bench/rtcs_top_tb.sv]
// Self-checking bench for the clock supervisor block
module rtcs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcs_pkg::*;
  localparam int LIMIT = 20000;
  logic clk, rst_n, ce_n, oe_n, we_n, ext_n, bank, fail, batt, kick, mwe_n;
  logic [3:0] addr;
  logic [7:0] wdat, dq, mdat, mwdat;
  logic dq_oe, b0_n, b1_n, rst_o, rst_oe, irq_o, irq_oe;
  logic [1:0] req_n;
  logic [7:0] vals [7] = '{8'h20, 8'h12, 8'h31, 8'h23, 8'h59, 8'h58, 8'h80};
  logic [7:0] yr [4] = '{8'h23, 8'h24, 8'h23, 8'h99};
  logic [7:0] mo [4] = '{8'h02, 8'h02, 8'h04, 8'h12};
  logic [7:0] dt [4] = '{8'h28, 8'h28, 8'h30, 8'h31};
  logic [7:0] emo [4] = '{8'h03, 8'h02, 8'h05, 8'h01};
  logic [7:0] edt [4] = '{8'h01, 8'h29, 8'h01, 8'h01};
  int mismatches, checks_done, cycles;

  rtcs_top #(.SUB_CYCLES(8)) DUT (.ref_clk_in(clk), .rst_n_in(rst_n),
    .chip_enable_n_in(ce_n), .output_enable_n_in(oe_n), .write_enable_n_in(we_n),
    .register_address_in(addr), .data_bus_in(wdat), .data_bus_out(dq),
    .data_bus_oe_out(dq_oe), .external_memory_select_in(ext_n), .bank_select_in(bank),
    .sram_bank0_select_out(b0_n), .sram_bank1_select_out(b1_n), .supply_fail_in(fail),
    .battery_low_in(batt), .watchdog_kick_in(kick), .reset_request_in_a(req_n[0]),
    .reset_request_in_b(req_n[1]), .reset_out(rst_o), .reset_oe_out(rst_oe),
    .interrupt_freqtest_out(irq_o), .interrupt_freqtest_oe_out(irq_oe));
  rtcs_sram_model u_mem (.clk_in(clk), .bank0_n_in(b0_n), .bank1_n_in(b1_n),
    .we_n_in(mwe_n), .wdata_in(mwdat), .rdata_out(mdat));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic give_verdict;
    $display("Mismatches %0d of %0d checks", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Strobe released for two full cycles so the next access sees it idle
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk); ce_n <= 1'b0; we_n <= 1'b0; addr <= a; wdat <= d;
    @(posedge clk); ce_n <= 1'b1; we_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : reg_wr

  task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk); ce_n <= 1'b0; oe_n <= 1'b0; addr <= a;
    @(posedge clk); #1;
    check8({7'h00, dq_oe}, 8'h01);
    check8(dq, exp);
    @(posedge clk); ce_n <= 1'b1; oe_n <= 1'b1;
  endtask : reg_chk

  task automatic mem_op(input logic b, input logic w, input logic [7:0] d);
    @(posedge clk); ext_n <= 1'b0; bank <= b; mwdat <= d;
    repeat (2) @(posedge clk);
    if (w) mwe_n <= 1'b0;
    else check8(mdat, d);
    @(posedge clk); mwe_n <= 1'b1; ext_n <= 1'b1;
  endtask : mem_op

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    {ce_n, oe_n, we_n, ext_n, mwe_n} = 5'h1F;
    {rst_n, bank, fail, batt, kick} = 5'h00;
    addr = 4'h0; wdat = 8'h00; mwdat = 8'h00; req_n = 2'b11;
    mismatches = 0; checks_done = 0; cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) reg_chk(i[3:0], (i >= 12 && i <= 14) ? 8'h01 : 8'h00);
    for (int i = 1; i < 8; i++) reg_wr(i[3:0], vals[i-1]);
    for (int i = 1; i < 8; i++) reg_chk(i[3:0], vals[i-1]);
    reg_wr(OFF_FLAGS, 8'hFF);
    reg_chk(OFF_FLAGS, 8'h00);
    @(posedge clk); fail <= 1'b1;
    reg_wr(OFF_CENTURY, 8'h55);
    check8({6'h00, b1_n, b0_n}, 8'h03);
    @(posedge clk); fail <= 1'b0;
    reg_chk(OFF_CENTURY, 8'h20);
    @(posedge clk); batt <= 1'b1;
    reg_chk(OFF_FLAGS, 8'h10);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk); {fail, ext_n, bank} <= k[2:0];
      repeat (2) @(posedge clk); #1;
      check8({b1_n, b0_n}, {!(k < 2 && k[0]), !(k == 0)});
    end
    @(posedge clk); fail <= 1'b0;
    mem_op(1'b0, 1'b1, 8'hA5);
    mem_op(1'b1, 1'b1, 8'h3C);
    @(posedge clk); fail <= 1'b1;
    mem_op(1'b0, 1'b1, 8'hFF);
    @(posedge clk); fail <= 1'b0;
    mem_op(1'b0, 1'b0, 8'hA5);
    mem_op(1'b1, 1'b0, 8'h3C);
    // Alarm set to the instant after the first rollover below
    reg_wr(OFF_ALM_MONTH, 8'h83);
    reg_wr(OFF_ALM_DATE, 8'h01);
    for (int i = 4; i < 7; i++) reg_wr(i[3:0], 8'h00);
    for (int c = 0; c < 4; c++) begin
      reg_wr(OFF_CONTROL, 8'h80);
      reg_wr(OFF_SEC, 8'h59);
      reg_wr(OFF_MIN, 8'h59);
      reg_wr(OFF_HOUR, 8'h23);
      reg_wr(OFF_DATE, dt[c]);
      reg_wr(OFF_MONTH, mo[c]);
      reg_wr(OFF_YEAR, yr[c]);
      // Refresh has overwritten the century cell, so set it with the rest
      reg_wr(OFF_CENTURY, 8'h20);
      reg_wr(OFF_CONTROL, 8'h00);
      repeat (136) @(posedge clk);
      reg_chk(OFF_SEC, 8'h00);
      reg_chk(OFF_HOUR, 8'h00);
      reg_chk(OFF_DATE, edt[c]);
      reg_chk(OFF_MONTH, emo[c]);
    end
    reg_chk(OFF_YEAR, 8'h00);
    reg_chk(OFF_CENTURY, 8'h21);
    check8({7'h00, irq_oe}, 8'h01);
    reg_chk(OFF_FLAGS, 8'h50);
    reg_chk(OFF_FLAGS, 8'h10);
    reg_wr(OFF_WATCHDOG, 8'h84);
    for (int n = 0; n < 64 && irq_oe !== 1'b1; n++) @(posedge clk);
    check8({7'h00, irq_oe}, 8'h01);
    reg_chk(OFF_FLAGS, 8'h90);
    repeat (2) @(posedge clk); #1;
    check8({7'h00, irq_oe}, 8'h00);
    reg_wr(OFF_WATCHDOG, 8'h04);
    @(posedge clk); kick <= 1'b1;
    for (int n = 0; n < 64 && rst_oe !== 1'b1; n++) @(posedge clk);
    check8({6'h00, irq_oe, rst_oe}, 8'h01);
    reg_wr(OFF_WATCHDOG, 8'h00);
    repeat (32) @(posedge clk); #1;
    check8({5'h00, irq_o, rst_o, rst_oe}, 8'h00);
    @(posedge clk); req_n <= 2'b10;
    repeat (2) @(posedge clk); #1;
    check8({7'h00, rst_oe}, 8'h01);
    @(posedge clk); req_n <= 2'b01;
    repeat (2) @(posedge clk); #1;
    check8({7'h00, rst_oe}, 8'h01);
    @(posedge clk); req_n <= 2'b11;
    repeat (2) @(posedge clk); #1;
    check8({7'h00, rst_oe}, 8'h00);
    give_verdict();
  end
endmodule : rtcs_top_tb
